// ### rtl/epfc_consts.vh
// register map, field positions, reset values and divider taps of the event counter
`ifndef EPFC_CONSTS_VH
`define EPFC_CONSTS_VH

// register indices; byte address is four times the index
`define EPFC_IDX_TIMEBASE_MODE  16'hffb0
`define EPFC_IDX_TIMEBASE_COUNT 16'hffb1
`define EPFC_IDX_EVENT_MODE     16'hffb4
`define EPFC_IDX_EVENT_COUNT    16'hffb5
`define EPFC_IDX_PORT3_MODE     16'hffca
`define EPFC_IDX_PORTB_MODE     16'hffee
`define EPFC_IDX_EDGE_SELECT    16'hfff2
`define EPFC_IDX_IRQ_ENABLE1    16'hfff3
`define EPFC_IDX_IRQ_ENABLE2    16'hfff4
`define EPFC_IDX_IRQ_REQUEST1   16'hfff6
`define EPFC_IDX_IRQ_REQUEST2   16'hfff7

// field positions
`define EPFC_BIT_TB_ENABLE      3
`define EPFC_BIT_DIR_HW         6
`define EPFC_BIT_DIR_DOWN       5
`define EPFC_BIT_UD_SELECT      0
`define EPFC_BIT_EVENT_SELECT   3
`define EPFC_BIT_EDGE_POLARITY  1
`define EPFC_BIT_TB_IRQ         7
`define EPFC_BIT_EV_IRQ         1

// clock source codes of the event counter
`define EPFC_CLK_SUB4           3'h6
`define EPFC_CLK_EVENT          3'h7

// prescaler tap widths: divide by 2**n
`define EPFC_TAP_8192           13
`define EPFC_TAP_2048           11
`define EPFC_TAP_512            9
`define EPFC_TAP_64             6
`define EPFC_TAP_16             4
`define EPFC_TAP_4              2
`define EPFC_SUB_DIV_W          2
`define EPFC_SUB_PSC_W          5

// reset values
`define EPFC_RST_BYTE           8'h00

// axi responses
`define EPFC_RESP_OKAY          2'h0
`define EPFC_RESP_SLVERR        2'h2

`endif

// ### rtl/epfc_top.v
// event pulse frequency counter: event counter, time base, flags and axi4-lite slave
// How it works
// - event count is 8 bits, read only
// - eight clock sources including event pin
// - direction from pin or fixed by software
// - direction pin low means counting up
// - overflow sets event overflow flag
// - request needs flag, enable, mask clear
// - 256 edges from zero overflow counter
// - polarity bit: 0 falling, 1 rising
// - port b bit 3 routes event pin
// - port 3 bit 0 enables direction pin
// - prescaler is 5 bits at sub/4
// - time base counts up at sub/128
// - enable1 bit 7 gates time-base request
// - enable2 bit 1 gates event request
// - request1 bit 7 shows time-base pending
// - request2 bit 1 shows event pending
`timescale 1ns/1ps
`default_nettype none
`include "epfc_consts.vh"

module epfc_top #(
  parameter AW = 18
) (
  // clock, reset, enable
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  // axi4-lite write address
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // axi4-lite read
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // pins and sub-clock
  input  wire          event_input_pin,
  input  wire          count_direction_pin,
  input  wire          subclk,
  // processor interrupt mask and requests
  input  wire          cpu_irq_mask,
  output reg           event_irq_req,
  output reg           timebase_irq_req
);

  // software-visible registers
  reg [7:0]  timebase_mode_reg;
  reg [7:0]  timebase_count;
  reg [7:0]  event_mode_reg;
  reg [7:0]  event_count;
  reg [7:0]  event_reload_reg;
  reg [7:0]  port3_pin_mode;
  reg [7:0]  portb_pin_mode;
  reg [7:0]  ext_irq_edge_select;
  reg        timebase_irq_enable;
  reg        event_irq_enable;
  reg        timebase_irq_flag;
  reg        event_overflow_flag;

  // internal state
  reg [12:0] sys_psc;
  reg [`EPFC_SUB_DIV_W-1:0] sub_div;
  reg [`EPFC_SUB_PSC_W-1:0] subclock_prescaler;
  reg [2:0]  ev_sync;
  reg [2:0]  dir_sync;
  reg [2:0]  sub_sync;
  reg        ev_level;
  reg        ev_level_d;
  reg        dir_level;
  reg        sub_level;
  reg        sub_level_d;

  // bus state
  reg          aw_held;
  reg          w_held;
  reg [AW-1:0] aw_addr_q;
  reg [7:0]    w_byte_q;
  reg          w_lane_q;

  // bus timing seen by software:
  //   a write is done one edge after the later of its address and data handshakes,
  //   and bvalid stands from that edge until the master takes it with bready;
  //   address and data ready stay low from their own handshake until then,
  //   so a second write cannot slip in behind a pending response.
  //   a read answers at the edge of its address handshake; rdata is frozen
  //   at that edge, so a slow rready never shows a newer count.
  // only byte lane 0 carries data; a write without wstrb[0] is answered okay
  // and changes nothing, which keeps partial writes harmless.

  // pin synchronisers: three stages, the filtered level moves once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      ev_sync   <= 3'h0;
      dir_sync  <= 3'h0;
      sub_sync  <= 3'h0;
      ev_level  <= 1'b0;
      ev_level_d <= 1'b0;
      dir_level <= 1'b0;
      sub_level <= 1'b0;
      sub_level_d <= 1'b0;
    end else if (ce) begin
      ev_sync  <= {ev_sync[1:0], event_input_pin};
      dir_sync <= {dir_sync[1:0], count_direction_pin};
      sub_sync <= {sub_sync[1:0], subclk};
      if (ev_sync[1] == ev_sync[2])
        ev_level <= ev_sync[2];
      if (dir_sync[1] == dir_sync[2])
        dir_level <= dir_sync[2];
      if (sub_sync[1] == sub_sync[2])
        sub_level <= sub_sync[2];
      ev_level_d  <= ev_level;
      sub_level_d <= sub_level;
    end
  end

  // event edge: one pulse per filtered transition of the chosen polarity
  wire ev_rise = ev_level & ~ev_level_d;
  wire ev_fall = ~ev_level & ev_level_d;
  wire ev_edge_raw = ext_irq_edge_select[`EPFC_BIT_EDGE_POLARITY] ? ev_rise : ev_fall;
  // pin is only an event input while port b routes it there
  wire ev_edge = ev_edge_raw & portb_pin_mode[`EPFC_BIT_EVENT_SELECT];

  // direction pin reads as low unless port 3 hands the pin over
  wire dir_pin_used = dir_level & port3_pin_mode[`EPFC_BIT_UD_SELECT];

  // sub-clock rising edges in the system clock domain
  wire sub_tick  = sub_level & ~sub_level_d;
  wire sub4_tick = sub_tick & (&sub_div);
  wire sub128_tick = sub4_tick & (&subclock_prescaler);

  // system prescaler taps, each high for one cycle per period
  wire [7:0] src_tick;
  assign src_tick[0] = &sys_psc[`EPFC_TAP_8192-1:0];
  assign src_tick[1] = &sys_psc[`EPFC_TAP_2048-1:0];
  assign src_tick[2] = &sys_psc[`EPFC_TAP_512-1:0];
  assign src_tick[3] = &sys_psc[`EPFC_TAP_64-1:0];
  assign src_tick[4] = &sys_psc[`EPFC_TAP_16-1:0];
  assign src_tick[5] = &sys_psc[`EPFC_TAP_4-1:0];
  assign src_tick[`EPFC_CLK_SUB4]  = sub4_tick;
  assign src_tick[`EPFC_CLK_EVENT] = ev_edge;

  wire ev_step = src_tick[event_mode_reg[2:0]];

  // direction: hardware pin, else software up or down
  wire ev_down = event_mode_reg[`EPFC_BIT_DIR_HW] ? dir_pin_used
                                                  : event_mode_reg[`EPFC_BIT_DIR_DOWN];
  wire ev_wrap = ev_step & (ev_down ? (event_count == 8'h00) : (event_count == 8'hff));

  // time base runs only in time-base mode
  wire tb_run  = timebase_mode_reg[`EPFC_BIT_TB_ENABLE];
  wire tb_wrap = tb_run & sub128_tick & (timebase_count == 8'hff);

  // prescalers and counters
  // the system prescaler runs free from reset; a newly chosen tap therefore
  // gives its first step anywhere within one divider period, not a full one.
  // the sub-clock path counts rising edges of the synchronised sub-clock, so
  // the sub-clock must stay well below a quarter of the system clock rate.
  // overflow and underflow share one wrap term, so reload and the request
  // flag always move together and cannot be split by a direction change.
  // a reload written while counting takes effect only at the next wrap;
  // the running count is never overwritten by software.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_psc            <= 13'h0000;
      sub_div            <= {`EPFC_SUB_DIV_W{1'b0}};
      subclock_prescaler <= {`EPFC_SUB_PSC_W{1'b0}};
      timebase_count     <= `EPFC_RST_BYTE;
      event_count        <= `EPFC_RST_BYTE;
    end else if (ce) begin
      sys_psc <= sys_psc + 13'h0001;
      if (sub_tick)
        sub_div <= sub_div + {{(`EPFC_SUB_DIV_W-1){1'b0}}, 1'b1};
      if (sub4_tick)
        subclock_prescaler <= subclock_prescaler + {{(`EPFC_SUB_PSC_W-1){1'b0}}, 1'b1};
      if (tb_run && sub128_tick)
        timebase_count <= timebase_count + 8'h01;
      // overflow reloads; with reload zero the 256th step from zero wraps here
      if (ev_wrap)
        event_count <= event_reload_reg;
      else if (ev_step && ev_down)
        event_count <= event_count - 8'h01;
      else if (ev_step)
        event_count <= event_count + 8'h01;
    end
  end

  // write decode
  wire [15:0] w_idx   = aw_addr_q[17:2];
  wire        w_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire        w_ok    = (w_idx == `EPFC_IDX_TIMEBASE_MODE)  | (w_idx == `EPFC_IDX_TIMEBASE_COUNT) |
                        (w_idx == `EPFC_IDX_EVENT_MODE)     | (w_idx == `EPFC_IDX_EVENT_COUNT) |
                        (w_idx == `EPFC_IDX_PORT3_MODE)     | (w_idx == `EPFC_IDX_PORTB_MODE) |
                        (w_idx == `EPFC_IDX_EDGE_SELECT)    | (w_idx == `EPFC_IDX_IRQ_ENABLE1) |
                        (w_idx == `EPFC_IDX_IRQ_ENABLE2)    | (w_idx == `EPFC_IDX_IRQ_REQUEST1) |
                        (w_idx == `EPFC_IDX_IRQ_REQUEST2);
  wire        w_do    = w_fire & w_ok & w_lane_q;
  // address bits above the 16-bit index must be zero; the shift form stays
  // legal when AW leaves no such bits at all
  wire        w_top   = (aw_addr_q >> 18) == {AW{1'b0}};

  // register writes; the counter address takes the reload value and leaves the count alone
  always @(posedge aclk) begin
    if (!aresetn) begin
      timebase_mode_reg   <= `EPFC_RST_BYTE;
      event_mode_reg      <= `EPFC_RST_BYTE;
      event_reload_reg    <= `EPFC_RST_BYTE;
      port3_pin_mode      <= `EPFC_RST_BYTE;
      portb_pin_mode      <= `EPFC_RST_BYTE;
      ext_irq_edge_select <= `EPFC_RST_BYTE;
      timebase_irq_enable <= 1'b0;
      event_irq_enable    <= 1'b0;
    end else if (ce && w_do && w_top) begin
      case (w_idx)
        `EPFC_IDX_TIMEBASE_MODE: timebase_mode_reg   <= w_byte_q;
        `EPFC_IDX_EVENT_MODE:    event_mode_reg      <= w_byte_q;
        `EPFC_IDX_EVENT_COUNT:   event_reload_reg    <= w_byte_q;
        `EPFC_IDX_PORT3_MODE:    port3_pin_mode      <= w_byte_q;
        `EPFC_IDX_PORTB_MODE:    portb_pin_mode      <= w_byte_q;
        `EPFC_IDX_EDGE_SELECT:   ext_irq_edge_select <= w_byte_q;
        `EPFC_IDX_IRQ_ENABLE1:   timebase_irq_enable <= w_byte_q[`EPFC_BIT_TB_IRQ];
        `EPFC_IDX_IRQ_ENABLE2:   event_irq_enable    <= w_byte_q[`EPFC_BIT_EV_IRQ];
        default: ;
      endcase
    end
  end

  // request flags: writing 0 clears, writing 1 keeps; a same-cycle event wins over the clear
  // software clears a flag with a read-modify-write of the request register;
  // letting the event win means an overflow landing on that write is never lost.
  // the request outputs are registered, so they trail the flag by one cycle
  // and also trail a change of the processor mask by one cycle.
  // this keeps every output straight from a flip-flop at the cost of a cycle.
  wire clr_tb = w_do & w_top & (w_idx == `EPFC_IDX_IRQ_REQUEST1) & ~w_byte_q[`EPFC_BIT_TB_IRQ];
  wire clr_ev = w_do & w_top & (w_idx == `EPFC_IDX_IRQ_REQUEST2) & ~w_byte_q[`EPFC_BIT_EV_IRQ];

  always @(posedge aclk) begin
    if (!aresetn) begin
      timebase_irq_flag   <= 1'b0;
      event_overflow_flag <= 1'b0;
      event_irq_req       <= 1'b0;
      timebase_irq_req    <= 1'b0;
    end else if (ce) begin
      if (tb_wrap)
        timebase_irq_flag <= 1'b1;
      else if (clr_tb)
        timebase_irq_flag <= 1'b0;
      if (ev_wrap)
        event_overflow_flag <= 1'b1;
      else if (clr_ev)
        event_overflow_flag <= 1'b0;
      // requests reach the processor only with enable set and mask clear
      event_irq_req    <= event_overflow_flag & event_irq_enable & ~cpu_irq_mask;
      timebase_irq_req <= timebase_irq_flag & timebase_irq_enable & ~cpu_irq_mask;
    end
  end

  // write channel: address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EPFC_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr_q     <= {AW{1'b0}};
      w_byte_q      <= 8'h00;
      w_lane_q      <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte_q     <= s_axi_wdata[7:0];
        w_lane_q     <= s_axi_wstrb[0];
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (w_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (w_ok & w_top) ? `EPFC_RESP_OKAY : `EPFC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read mux; reading the count never touches the counter
  reg [7:0] r_byte;
  reg       r_ok;
  wire [15:0] r_idx = s_axi_araddr[17:2];
  wire        r_top = (s_axi_araddr >> 18) == {AW{1'b0}};

  always @* begin
    r_byte = 8'h00;
    r_ok   = r_top;
    case (r_idx)
      `EPFC_IDX_TIMEBASE_MODE:  r_byte = timebase_mode_reg;
      `EPFC_IDX_TIMEBASE_COUNT: r_byte = timebase_count;
      `EPFC_IDX_EVENT_MODE:     r_byte = event_mode_reg;
      `EPFC_IDX_EVENT_COUNT:    r_byte = event_count;
      `EPFC_IDX_PORT3_MODE:     r_byte = port3_pin_mode;
      `EPFC_IDX_PORTB_MODE:     r_byte = portb_pin_mode;
      `EPFC_IDX_EDGE_SELECT:    r_byte = ext_irq_edge_select;
      `EPFC_IDX_IRQ_ENABLE1:    r_byte = {timebase_irq_enable, 7'h00};
      `EPFC_IDX_IRQ_ENABLE2:    r_byte = {6'h00, event_irq_enable, 1'b0};
      `EPFC_IDX_IRQ_REQUEST1:   r_byte = {timebase_irq_flag, 7'h00};
      `EPFC_IDX_IRQ_REQUEST2:   r_byte = {6'h00, event_overflow_flag, 1'b0};
      default:                  r_ok = 1'b0;
    endcase
  end

  // read channel: data captured at the address handshake, so one cycle to answer
  // arready drops at the handshake and returns only after rvalid is taken,
  // so one read at most is under way; reads and writes run independently.
  // an unmapped index answers zero data with a slave error, and has no effect.
  // the event counter shares its index with the reload register: reads see
  // the count, writes land in the reload value.
  // with ce low the whole slave freezes, handshakes included, so a master
  // simply sees ready or valid held a little longer.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `EPFC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, r_ok ? r_byte : 8'h00};
        s_axi_rresp   <= r_ok ? `EPFC_RESP_OKAY : `EPFC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // epfc_top

`default_nettype wire

// ### verification/epfc_properties.sv
// checker: bus handshake and interrupt request timing of the event counter
`timescale 1ns/1ps
`default_nettype none
`include "epfc_consts.vh"
module epfc_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // requests
  input wire logic        cpu_irq_mask,
  input wire logic        event_irq_req,
  input wire logic        timebase_irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response missing");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_write_done: assert property (ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready) else $error("write channel not freed");
  a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    ##0 !s_axi_arready) else $error("read data missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data changed");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_masked: assert property (ce && cpu_irq_mask |=> !event_irq_req
    && !timebase_irq_req) else $error("request passed the mask");
  a_irq_rise: assert property ($rose(event_irq_req) |-> $past(!cpu_irq_mask))
    else $error("request rose while masked");
  cover property ($rose(event_irq_req));
  cover property (s_axi_bvalid && s_axi_bresp == `EPFC_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // epfc_properties
bind epfc_top epfc_properties i_props (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_irq_mask(cpu_irq_mask),
  .event_irq_req(event_irq_req), .timebase_irq_req(timebase_irq_req));
`default_nettype wire

// ### verification/epfc_pulse_src.sv
// partner model: external pulse source on the event input pin
`timescale 1ns/1ps
`default_nettype none
module epfc_pulse_src (
  // clock and pin
  input wire logic aclk,
  output var logic pin
);
  initial pin = 1'b0;
  // both levels last two cycles or more, else the input filter may swallow them
  task automatic send(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      pin <= 1'b1;
      repeat (hi) @(posedge aclk);
      pin <= 1'b0;
      repeat (lo) @(posedge aclk);
    end
  endtask
endmodule // epfc_pulse_src
`default_nettype wire

// ### verification/epfc_top_tb_top.sv
// testbench: register bus, pulse counting, routing, direction and clock sources
`timescale 1ns/1ps
`default_nettype none
`include "epfc_consts.vh"
module epfc_top_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin, dir, mask, subclk;
  logic        awready, wready, bvalid, arready, rvalid, eirq, tirq;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  b, c0, d, tally, resid;
  logic        fin;
  int          num_errors, n_compared, k, j, freq;
  int          dv[7] = '{8192, 2048, 512, 64, 16, 4, 32};
  epfc_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .event_input_pin(pin), .count_direction_pin(dir), .subclk(subclk),
    .cpu_irq_mask(mask), .event_irq_req(eirq), .timebase_irq_req(tirq));
  epfc_pulse_src src (.aclk(aclk), .pin(pin));
  // clocks; the sub-clock runs scaled up (8 cycles) so time-base ticks fit the run
  always #10 aclk = ~aclk;
  always #80 subclk = ~subclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic results;
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    int t;
    logic sa, sw, sb;
    t = 0;
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // readies and response are sampled mid-cycle, settled, for the next edge
    do begin
      @(negedge aclk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
      t++;
    end while (sb !== 1'b1 && t < 50);
    bready <= 1'b0;
    @(posedge aclk);
    if (t >= 50) num_errors++;
  endtask
  task automatic rd(input logic [15:0] a);
    int t;
    logic sa, sv;
    t = 0;
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      sa = arready;
      sv = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (sa) arvalid <= 1'b0;
      t++;
    end while (sv !== 1'b1 && t < 50);
    rready <= 1'b0;
    @(posedge aclk);
    if (t >= 50) num_errors++;
  endtask
  task automatic cc(input logic [7:0] e);
    rd(16'hffb5);
    chk("event_count", {24'h0, e}, rv);
  endtask
  task automatic pulses(input int n);
    src.send(n, $urandom_range(6, 3), $urandom_range(6, 3));
    repeat (8) @(posedge aclk);
  endtask
  // watchdog about twice the roughly 45k cycles of the sequence
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    results();
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dir, mask, subclk} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(23686));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(16'hfff7);
    chk("irq_request_second", 32'h0, rv);
    wr(16'hffb5, 8'h33);
    cc(8'h00);
    wr(16'hffb2, 8'h01);
    chk("bresp", `EPFC_RESP_SLVERR, rs);
    rd(16'hffb2);
    chk("rresp", `EPFC_RESP_SLVERR, rs);
    chk("rdata", 32'h0, rv);
    wr(16'hffee, 8'h08);
    wr(16'hfff2, 8'h02);
    wr(16'hffca, 8'h01);
    wr(16'hfff4, 8'h02);
    wr(16'hffb5, 8'h00);
    wr(16'hffb4, 8'h7f);
    rd(16'hffb5);
    b = rv[7:0];
    k = $urandom_range(120, 1);
    j = $urandom_range(120, 1);
    pulses(k);
    cc(b + k);
    pulses(j);
    cc(b + k + j);
    rd(16'hfff7);
    chk("irq_request_second", 32'h0, rv);
    pulses(256 - (b + k + j));
    cc(8'h00);
    rd(16'hfff7);
    chk("irq_request_second", 32'h2, rv);
    chk("event_irq_req", 32'h1, eirq);
    mask <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("event_irq_req", 32'h0, eirq);
    mask <= 1'b0;
    wr(16'hfff4, 8'h00);
    repeat (3) @(posedge aclk);
    chk("event_irq_req", 32'h0, eirq);
    wr(16'hfff4, 8'h02);
    wr(16'hfff7, 8'h00);
    rd(16'hfff7);
    chk("irq_request_second", 32'h0, rv);
    wr(16'hffb5, 8'hf0);
    pulses(256);
    cc(8'hf0);
    // falling-edge sense: the long high phase must not count
    wr(16'hfff2, 8'h00);
    fork
      src.send(1, 40, 3);
      begin
        repeat (20) @(posedge aclk);
        cc(8'hf0);
      end
    join
    repeat (8) @(posedge aclk);
    cc(8'hf1);
    wr(16'hfff2, 8'h02);
    wr(16'hffee, 8'h00);
    pulses(5);
    cc(8'hf1);
    wr(16'hffee, 8'h08);
    dir <= 1'b1;
    pulses(2);
    cc(8'hef);
    wr(16'hffca, 8'h00);
    pulses(2);
    cc(8'hf1);
    wr(16'hffb4, 8'h27);
    pulses(1);
    cc(8'hf0);
    dir <= 1'b0;
    // internal sources: two divider periods give one to three steps with bus latency
    wr(16'hffb5, 8'h00);
    for (int s = 0; s < 7; s++) begin
      wr(16'hffb4, s[7:0]);
      rd(16'hffb5);
      c0 = rv[7:0];
      repeat (2 * dv[s]) @(posedge aclk);
      rd(16'hffb5);
      d = rv[7:0] - c0;
      chk("source_steps", 32'h1, d inside {[1:3]});
    end
    // gate measurement the way software runs it: tally overflows, capture at gate end
    wr(16'hffb4, 8'h7f);
    rd(16'hffb5);
    c0 = rv[7:0];
    pulses(256 - c0);
    wr(16'hfff7, 8'h00);
    {tally, resid, fin} = '0;
    k = $urandom_range(400, 257);
    pulses(256);
    rd(16'hfff7);
    if (rv[1]) tally++;
    wr(16'hfff7, 8'h00);
    if (tally == 8'hff) {tally, resid} = '0;
    pulses(k - 256);
    mask <= 1'b1;
    rd(16'hffb5);
    resid = rv[7:0];
    fin = 1'b1;
    freq = tally * 256 + resid;
    chk("frequency", k, freq);
    chk("completion_flag", 32'h1, fin);
    mask <= 1'b0;
    wr(16'hffb0, 8'h18);
    wr(16'hfff3, 8'h80);
    rd(16'hffb1);
    c0 = rv[7:0];
    repeat (10240) @(posedge aclk);
    rd(16'hffb1);
    d = rv[7:0] - c0;
    chk("timebase_steps", 32'h1, d inside {[9:11]});
    results();
  end
endmodule // epfc_top_tb_top
`default_nettype wire
